// ---- common/acar_pkg.sv ----
// Behaviour
// RULE1: Bits 15:12 of every register word select the target register.
// RULE2: Lane select bit 8 at 0 drives results on lanes A and B.
// RULE3: Lane select bit 8 at 1 sends all results on lane A only.
// RULE4: Reset code 0x3c starts a soft reset; register contents stay unchanged.
// RULE5: Soft reset clears the alert flags except bit 8 and flushes oversampling and state machines.
// RULE6: Reset code 0xff starts a hard reset; registers return to defaults.
// RULE7: Any other reset field value has no effect.
// RULE8: Bit 9 sets on a write rejected by check code; clears on read.
// RULE9: Bit 8 sets when startup configuration data fails to load.
// RULE10: Bit 8 survives reads; only hard reset clears it and restarts setup.
// RULE11: Bit 5 sets when channel B result exceeds upper threshold; read clears.
// RULE12: Bit 4 sets when channel B result is below lower threshold; read clears.
// RULE13: Flag pin enable routes alerts to lane B only in one-lane mode.
// RULE14: A flag event coinciding with an alert read stays set after it.
package acar_pkg;

    localparam logic [3:0] ACAR_ADDR_CONFIG2 = 4'h2;
    localparam logic [3:0] ACAR_ADDR_ALERT = 4'h3;
    localparam int ACAR_ADDR_MSB = 15;
    localparam int ACAR_ADDR_LSB = 12;
    localparam int ACAR_LANE_BIT = 8;
    localparam int ACAR_RST_MSB = 7;
    localparam logic [7:0] ACAR_SOFT_CODE = 8'h3c;
    localparam logic [7:0] ACAR_HARD_CODE = 8'hff;
    localparam logic [15:0] ACAR_CONFIG2_RESET = 16'h0000;
    localparam logic [15:0] ACAR_ALERT_RESET = 16'h0000;
    localparam logic ACAR_LANE_RESET = 1'h0;
    localparam int ACAR_WCF_BIT = 9;
    localparam int ACAR_SETUP_BIT = 8;
    localparam int ACAR_OVER_BIT = 5;
    localparam int ACAR_UNDER_BIT = 4;

    typedef struct packed {
        logic write_check_fail;
        logic setup_fail;
        logic chan_b_over;
        logic chan_b_under;
    } acar_alert_s;

    localparam acar_alert_s ACAR_ALERT_CLEAR = 4'h0;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } acar_word_s;

    typedef struct packed {
        logic valid;
        logic [15:0] result;
    } acar_sample_s;

endpackage : acar_pkg

// ---- src/acar_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module acar_regs
    import acar_pkg::*;
(
    input wire logic clk, // 125 MHz serial interface clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire acar_word_s wr, // Accepted register write word
    input wire logic rd_req, // Register read request
    input wire logic [3:0] rd_addr, // Register select of the read
    input wire logic write_check_fail_evt, // Write rejected by check code
    input wire logic setup_fail_evt, // Startup configuration load failed
    input wire acar_sample_s chan_b_sample, // Channel B conversion result
    input wire logic [15:0] thr_high, // Upper alert threshold
    input wire logic [15:0] thr_low, // Lower alert threshold
    input wire logic flag_pin_enable, // Alert indicator routing request
    output logic rd_valid_q, // Read data valid pulse
    output logic [15:0] rd_data_q, // Read data word
    output logic output_lane_select_q, // 1 selects one-lane output
    output logic lane_b_results_q, // Lane B carries conversion results
    output logic serial_out_lane_b_flag_q, // Alert level driven on lane B
    output logic soft_reset_q, // Soft reset pulse to internal blocks
    output logic hard_reset_q, // Hard reset pulse, restarts setup
    output acar_alert_s alert_q // Sticky alert flags
);

    wire wr_cfg = wr.valid &&
        (wr.word[ACAR_ADDR_MSB:ACAR_ADDR_LSB] == ACAR_ADDR_CONFIG2); // [RULE1]
    wire [7:0] rst_code = wr.word[ACAR_RST_MSB:0];
    wire soft_hit = wr_cfg && (rst_code == ACAR_SOFT_CODE); // [RULE4]
    wire hard_hit = wr_cfg && (rst_code == ACAR_HARD_CODE); // [RULE6]
    wire plain_cfg = wr_cfg && !soft_hit && !hard_hit; // [RULE7]
    wire rd_alert = rd_req && (rd_addr == ACAR_ADDR_ALERT); // [RULE1]
    wire rd_cfg = rd_req && (rd_addr == ACAR_ADDR_CONFIG2);

    // A soft reset leaves the register untouched, a hard one restores the default.
    wire lane_d = hard_hit ? ACAR_LANE_RESET : // [RULE6]
                  plain_cfg ? wr.word[ACAR_LANE_BIT] : // [RULE7]
                  output_lane_select_q; // [RULE4]

    wire over_evt = chan_b_sample.valid && (chan_b_sample.result > thr_high); // [RULE11]
    wire under_evt = chan_b_sample.valid && (chan_b_sample.result < thr_low); // [RULE12]

    // Events always win over a clear, so nothing raised in a clearing cycle is lost.
    wire sticky_clr = rd_alert || soft_hit || hard_hit; // [RULE5] [RULE8]
    wire [2:0] sticky_evt = {write_check_fail_evt, over_evt, under_evt};
    wire [2:0] sticky_now = {alert_q.write_check_fail, alert_q.chan_b_over,
        alert_q.chan_b_under};
    wire [2:0] sticky_nxt;

    // The three read-cleared flags share one behaviour, so they share one loop.
    for (genvar i = 0; i < 3; i++) begin : g_sticky
        assign sticky_nxt[i] = sticky_evt[i] || (sticky_now[i] && !sticky_clr); // [RULE14]
    end

    acar_alert_s alert_d;
    assign alert_d.write_check_fail = sticky_nxt[2]; // [RULE8]
    assign alert_d.setup_fail = setup_fail_evt ||
        (alert_q.setup_fail && !hard_hit); // [RULE9] [RULE10]
    assign alert_d.chan_b_over = sticky_nxt[1]; // [RULE11]
    assign alert_d.chan_b_under = sticky_nxt[0]; // [RULE12]

    // The indicator function only exists when lane B is free of results.
    wire flag_d = lane_d && flag_pin_enable && (|alert_d); // [RULE13]

    wire [15:0] cfg_word = {ACAR_ADDR_CONFIG2, 3'h0, output_lane_select_q, 8'h00};
    wire [15:0] alert_word = {ACAR_ADDR_ALERT, 2'h0, alert_q.write_check_fail,
        alert_q.setup_fail, 2'h0, alert_q.chan_b_over, alert_q.chan_b_under, 4'h0};
    wire [15:0] rd_data_d = rd_cfg ? cfg_word :
                            rd_alert ? alert_word :
                            {rd_addr, 12'h000}; // [RULE1]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_lane_select_q <= ACAR_LANE_RESET;
            lane_b_results_q <= !ACAR_LANE_RESET;
        end else begin
            output_lane_select_q <= lane_d; // [RULE2] [RULE3]
            lane_b_results_q <= !lane_d; // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_lane_b_flag_q <= 1'h0;
        end else begin
            serial_out_lane_b_flag_q <= flag_d; // [RULE13]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_q <= ACAR_ALERT_CLEAR;
        end else begin
            alert_q <= alert_d; // [RULE14]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_q <= 1'h0;
            hard_reset_q <= 1'h0;
        end else begin
            soft_reset_q <= soft_hit; // [RULE5]
            hard_reset_q <= hard_hit; // [RULE10]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'h0;
        end else begin
            rd_valid_q <= rd_req;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= ACAR_ALERT_RESET;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    chk_addr_field: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        rd_req |=> rd_valid_q && rd_data_q[15:12] == $past(rd_addr))
        else $error("Read word does not carry its register select.");

    chk_two_lane: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        !output_lane_select_q |-> lane_b_results_q && !serial_out_lane_b_flag_q)
        else $error("Two-lane mode without results on lane B.");

    chk_one_lane: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        wr.valid && wr.word == 16'h2100 |=> output_lane_select_q && !lane_b_results_q)
        else $error("One-lane write did not take lane B off results.");

    chk_soft_keeps: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        soft_hit |=> soft_reset_q && !hard_reset_q &&
        output_lane_select_q == $past(output_lane_select_q))
        else $error("Soft reset changed the lane select or missed its pulse.");

    chk_soft_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
        soft_hit && !write_check_fail_evt && !over_evt && !under_evt |=>
        !alert_q.write_check_fail && !alert_q.chan_b_over && !alert_q.chan_b_under)
        else $error("Soft reset left a sticky alert flag set.");

    chk_hard_default: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        hard_hit && !setup_fail_evt |=> hard_reset_q && !output_lane_select_q &&
        !alert_q.setup_fail)
        else $error("Hard reset did not restore defaults.");

    chk_other_code: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        plain_cfg |=> !soft_reset_q && !hard_reset_q &&
        output_lane_select_q == $past(wr.word[ACAR_LANE_BIT]))
        else $error("Ignored reset code had an effect.");

    chk_wcf_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        alert_q.write_check_fail && rd_alert && !write_check_fail_evt ##1
        rd_valid_q |-> rd_data_q[ACAR_WCF_BIT] && !alert_q.write_check_fail)
        else $error("Write check flag not reported then cleared by read.");

    chk_setup_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        setup_fail_evt |=> alert_q.setup_fail [*2] or
        (alert_q.setup_fail ##1 $past(hard_hit)))
        else $error("Startup load failure flag did not set.");

    chk_setup_read: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        alert_q.setup_fail && !hard_hit |=> alert_q.setup_fail)
        else $error("Startup load failure flag cleared without hard reset.");

    chk_over_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        chan_b_sample.valid && chan_b_sample.result > thr_high |=> alert_q.chan_b_over)
        else $error("Upper threshold crossing not flagged.");

    chk_under_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        chan_b_sample.valid && chan_b_sample.result < thr_low |=> alert_q.chan_b_under)
        else $error("Lower threshold crossing not flagged.");

    chk_flag_pin: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        serial_out_lane_b_flag_q |-> output_lane_select_q && (|alert_q) &&
        $past(flag_pin_enable))
        else $error("Alert driven on lane B outside one-lane mode.");

    chk_read_race: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
        rd_alert && (write_check_fail_evt || over_evt || under_evt) |=>
        (alert_q.write_check_fail || alert_q.chan_b_over || alert_q.chan_b_under))
        else $error("Event lost in the cycle of an alert read.");

    chk_lane_inverse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        output_lane_select_q |->
        !lane_b_results_q)
        else $error("Lane B still carries results in one-lane mode.");

    chk_lane_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        !wr_cfg |=>
        $stable(output_lane_select_q))
        else $error("Lane select changed without a configuration write.");

    chk_read_strobe: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        !rd_req |=>
        !rd_valid_q)
        else $error("Read strobe raised without a read request.");

    chk_cfg_word: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        rd_cfg |=>
        rd_data_q == {ACAR_ADDR_CONFIG2, 3'h0, $past(output_lane_select_q), 8'h00})
        else $error("Configuration read word is wrong.");

    chk_wcf_word: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        rd_alert |=>
        rd_data_q[ACAR_WCF_BIT] == $past(alert_q.write_check_fail))
        else $error("Write check flag misreported on read.");

    chk_setup_word: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        rd_alert |=>
        rd_data_q[ACAR_SETUP_BIT] == $past(alert_q.setup_fail))
        else $error("Startup load flag misreported on read.");

    chk_over_word: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        rd_alert |=>
        rd_data_q[ACAR_OVER_BIT] == $past(alert_q.chan_b_over))
        else $error("Upper threshold flag misreported on read.");

    chk_under_word: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        rd_alert |=>
        rd_data_q[ACAR_UNDER_BIT] == $past(alert_q.chan_b_under))
        else $error("Lower threshold flag misreported on read.");

    chk_alert_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        rd_alert |=>
        rd_data_q[11:10] == 2'h0 && rd_data_q[7:6] == 2'h0 && rd_data_q[3:0] == 4'h0)
        else $error("Reserved alert bits read nonzero.");

    chk_wcf_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        write_check_fail_evt |=>
        alert_q.write_check_fail)
        else $error("Write check failure not flagged.");

    chk_wcf_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        alert_q.write_check_fail && !sticky_clr |=>
        alert_q.write_check_fail)
        else $error("Write check flag dropped without a clear.");

    chk_over_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        alert_q.chan_b_over && !sticky_clr |=>
        alert_q.chan_b_over)
        else $error("Upper threshold flag dropped without a clear.");

    chk_under_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        alert_q.chan_b_under && !sticky_clr |=>
        alert_q.chan_b_under)
        else $error("Lower threshold flag dropped without a clear.");

    chk_over_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        alert_q.chan_b_over && rd_alert && !over_evt |=>
        !alert_q.chan_b_over)
        else $error("Upper threshold flag survived an alert read.");

    chk_under_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        alert_q.chan_b_under && rd_alert && !under_evt |=>
        !alert_q.chan_b_under)
        else $error("Lower threshold flag survived an alert read.");

    chk_over_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        !alert_q.chan_b_over && !over_evt |=>
        !alert_q.chan_b_over)
        else $error("Upper threshold flag set without a crossing.");

    chk_under_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        !alert_q.chan_b_under && !under_evt |=>
        !alert_q.chan_b_under)
        else $error("Lower threshold flag set without a crossing.");

    chk_setup_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        !alert_q.setup_fail && !setup_fail_evt |=>
        !alert_q.setup_fail)
        else $error("Startup load flag set without a failure.");

    chk_pulse_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        !soft_hit && !hard_hit |=>
        !soft_reset_q && !hard_reset_q)
        else $error("Reset pulse without a reset code.");

    chk_flag_off: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        !flag_pin_enable |=>
        !serial_out_lane_b_flag_q)
        else $error("Alert driven on lane B while the indicator is off.");

    chk_flag_raise: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        lane_d && flag_pin_enable && (|alert_d) |=>
        serial_out_lane_b_flag_q)
        else $error("Alert not driven on lane B in one-lane mode.");

    chk_hard_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        hard_hit && !write_check_fail_evt && !over_evt && !under_evt |=>
        !alert_q.write_check_fail && !alert_q.chan_b_over && !alert_q.chan_b_under)
        else $error("Hard reset left a sticky alert flag set.");

    cov_soft: cover property (@(posedge clk) disable iff (!rst_n)
        alert_q.chan_b_over ##1 soft_hit ##1 !alert_q.chan_b_over);

    cov_hard: cover property (@(posedge clk) disable iff (!rst_n)
        alert_q.setup_fail ##1 hard_hit ##1 hard_reset_q);

    cov_flag: cover property (@(posedge clk) disable iff (!rst_n)
        serial_out_lane_b_flag_q ##[1:20] rd_alert);

    cov_race: cover property (@(posedge clk) disable iff (!rst_n)
        rd_alert && write_check_fail_evt);

    cov_one_lane: cover property (@(posedge clk) disable iff (!rst_n)
        plain_cfg && wr.word[ACAR_LANE_BIT] ##1 output_lane_select_q);

endmodule : acar_regs
`default_nettype wire

// ---- verification/acar_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module acar_host_model
    import acar_pkg::*;
(
    input wire logic clk, // Interface clock
    input wire logic rd_valid_q, // Read answer strobe
    input wire logic [15:0] rd_data_q, // Read answer word
    output acar_word_s wr, // Write word to the block
    output logic rd_req, // Read request
    output logic [3:0] rd_addr // Read register select
);
    initial begin
        wr = '{valid: 1'b0, word: 16'h5a5a};
        rd_req = 1'b0;
        rd_addr = 4'ha;
    end
    // Released lines show the inverse so that a stale value is never mistaken for a live one.
    task automatic write_word(input logic [15:0] w);
        @(posedge clk);
        #1 wr = '{valid: 1'b1, word: w};
        @(posedge clk);
        #1 wr = '{valid: 1'b0, word: ~w};
    endtask : write_word
    task automatic read_word(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        #1 rd_req = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1 rd_req = 1'b0;
        rd_addr = ~a;
        d = (rd_valid_q === 1'b1) ? rd_data_q : 16'hdead;
    endtask : read_word
endmodule : acar_host_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acar_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    acar_word_s wr;
    logic rd_req, rd_valid, lane_sel, lane_b_res, flag_out, soft_rst, hard_rst;
    logic [3:0] rd_addr;
    logic [15:0] rd_data, rdv;
    logic wcf_evt = 1'b0;
    logic setup_evt = 1'b0;
    acar_sample_s smp = '0;
    logic [15:0] thr_hi = 16'h8000;
    logic [15:0] thr_lo = 16'h0010;
    logic fpe = 1'b1;
    acar_alert_s alert;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    acar_host_model host_u (.clk(clk), .rd_valid_q(rd_valid), .rd_data_q(rd_data), .wr(wr),
        .rd_req(rd_req), .rd_addr(rd_addr));
    acar_regs dut_u (.clk(clk), .rst_n(rst_n), .wr(wr), .rd_req(rd_req), .rd_addr(rd_addr),
        .write_check_fail_evt(wcf_evt), .setup_fail_evt(setup_evt), .chan_b_sample(smp),
        .thr_high(thr_hi), .thr_low(thr_lo), .flag_pin_enable(fpe),
        .rd_valid_q(rd_valid), .rd_data_q(rd_data), .output_lane_select_q(lane_sel),
        .lane_b_results_q(lane_b_res), .serial_out_lane_b_flag_q(flag_out),
        .soft_reset_q(soft_rst), .hard_reset_q(hard_rst), .alert_q(alert));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // One-cycle pulse on the event inputs; a sample result of 16'h4000 lies between thresholds.
    task automatic ev(input logic w, input logic s, input logic [15:0] r);
        @(posedge clk);
        #1 {wcf_evt, setup_evt, smp} = {w, s, 1'b1, r};
        @(posedge clk);
        #1 {wcf_evt, setup_evt, smp} = {2'b00, 1'b0, ~r};
    endtask : ev
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        check(lane_b_res, 16'h1);
        host_u.read_word(ACAR_ADDR_CONFIG2, rdv);
        check(rdv, 16'h2000);
        host_u.read_word(ACAR_ADDR_ALERT, rdv);
        check(rdv, 16'h3000);
        host_u.write_word(16'h2100);
        check({lane_sel, lane_b_res}, 16'h2);
        host_u.write_word(16'h5000);
        check(lane_sel, 16'h1);
        ev(1'b1, 1'b1, 16'h9000);
        ev(1'b0, 1'b0, 16'h0001);
        check(alert, 16'hf);
        check(flag_out, 16'h1);
        host_u.read_word(ACAR_ADDR_ALERT, rdv);
        check(rdv, 16'h3330);
        check(alert, 16'h4);
        fork
            host_u.read_word(ACAR_ADDR_ALERT, rdv);
            ev(1'b1, 1'b0, 16'h4000);
        join
        check(rdv, 16'h3100);
        check(alert, 16'hc);
        ev(1'b0, 1'b0, 16'h9000);
        host_u.write_word(16'h203c);
        check({soft_rst, hard_rst, lane_sel}, 16'h5);
        check(alert, 16'h4);
        host_u.write_word(16'h2055);
        check({soft_rst, hard_rst, lane_sel, lane_b_res}, 16'h1);
        ev(1'b0, 1'b0, 16'h9000);
        check({alert, flag_out}, 16'hc);
        host_u.write_word(16'h21ff);
        check({hard_rst, lane_sel, alert}, 16'h20);
        host_u.read_word(ACAR_ADDR_CONFIG2, rdv);
        check(rdv, 16'h2000);
        host_u.write_word(16'h2100);
        @(posedge clk);
        #1 fpe = 1'b0;
        ev(1'b0, 1'b0, 16'h9000);
        check({alert, flag_out}, 16'h4);
        @(posedge clk);
        #1 fpe = 1'b1;
        @(posedge clk);
        #1 check(flag_out, 16'h1);
        host_u.read_word(ACAR_ADDR_ALERT, rdv);
        check(rdv, 16'h3020);
        @(posedge clk);
        #1 {thr_hi, thr_lo} = {16'h9000, 16'h9000};
        ev(1'b0, 1'b0, 16'h9000);
        check({alert, flag_out}, 16'h0);
        ev(1'b0, 1'b0, 16'h8fff);
        check({alert, flag_out}, 16'h3);
        @(posedge clk);
        #1 rst_n = 1'b0;
        #1 check({lane_sel, lane_b_res, flag_out, alert}, 16'h20);
        @(posedge clk);
        #1 rst_n = 1'b1;
        host_u.read_word(ACAR_ADDR_ALERT, rdv);
        check(rdv, 16'h3000);
        check({lane_sel, lane_b_res}, 16'h1);
        results();
    end
endmodule : tb
`default_nettype wire
